/* File: vocr_map.svh */
// Offsets, field positions and timing counts for the offset/compensation bank
`ifndef VOCR_MAP_SVH
`define VOCR_MAP_SVH
`define VOCR_OFS_OFFSET_TRIM   8'ha8
`define VOCR_OFS_COMP_PRIMARY  8'ha9
`define VOCR_OFS_COMP_SECOND   8'haa
`define VOCR_GAIN_MSB          7
`define VOCR_GAIN_LSB          4
`define VOCR_AC_LOAD_LINE_MSB          3
`define VOCR_AC_LOAD_LINE_LSB          0
`define VOCR_IGAIN_MSB         7
`define VOCR_IGAIN_LSB         6
`define VOCR_ITIME_MSB         5
`define VOCR_ITIME_LSB         3
`define VOCR_RAMP_MSB          2
`define VOCR_RAMP_LSB          0
`define VOCR_GAIN_RSVD_FIRST   4'hc
`define VOCR_NVM_LOAD_CYCLES   3'h3
`define VOCR_RST_BYTE          8'h00
`endif

/* File: vocr_pkg.sv */
// Types shared by the offset/compensation register bank
`default_nettype none
package vocr_pkg;
   typedef enum logic [1:0] {
      VOCR_ST_RESET = 2'b00,
      VOCR_ST_LOAD  = 2'b01,
      VOCR_ST_READY = 2'b10
   } vocr_state_e;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] cmd;
      logic [7:0] wdata;
   } vocr_req_s;
   typedef struct packed {
      logic [7:0] offset_trim;
      logic [7:0] comp_primary;
      logic [7:0] comp_second;
   } vocr_nvm_s;
   // Offset in tenths of a millivolt, signed
   typedef logic signed [11:0] vocr_tenth_mv_t;
endpackage
`default_nettype wire

/* File: vocr_decode.sv */
// Decoders from register codes to analog settings in tenths of a unit
`timescale 1ns/10ps
`default_nettype none
`include "vocr_map.svh"
module vocr_decode (
   input  wire logic [7:0]  i_comp_primary,
   output logic      [6:0]  o_ac_path_gain_x10,
   output logic      [7:0]  o_ac_load_line_x10,
   output logic             o_gain_reserved
);
   logic [3:0] gain_code;
   logic [3:0] ll_code;
   assign gain_code = i_comp_primary[`VOCR_GAIN_MSB:`VOCR_GAIN_LSB];
   assign ll_code   = i_comp_primary[`VOCR_AC_LOAD_LINE_MSB:`VOCR_AC_LOAD_LINE_LSB];
   assign o_gain_reserved = (gain_code >= `VOCR_GAIN_RSVD_FIRST);

   // Gain table; reserved codes fall back to the lowest gain for safety
   always_comb begin
      case (gain_code)
         4'h0:    o_ac_path_gain_x10 = 7'h03;
         4'h1:    o_ac_path_gain_x10 = 7'h05;
         4'h2:    o_ac_path_gain_x10 = 7'h0a;
         4'h3:    o_ac_path_gain_x10 = 7'h0f;
         4'h4:    o_ac_path_gain_x10 = 7'h14;
         4'h5:    o_ac_path_gain_x10 = 7'h19;
         4'h6:    o_ac_path_gain_x10 = 7'h1e;
         4'h7:    o_ac_path_gain_x10 = 7'h23;
         4'h8:    o_ac_path_gain_x10 = 7'h28;
         4'h9:    o_ac_path_gain_x10 = 7'h32;
         4'ha:    o_ac_path_gain_x10 = 7'h3c;
         4'hb:    o_ac_path_gain_x10 = 7'h46;
         default: o_ac_path_gain_x10 = 7'h03;
      endcase
   end

   // Load-line table, all sixteen codes in use
   always_comb begin
      case (ll_code)
         4'h0:    o_ac_load_line_x10 = 8'h05;
         4'h1:    o_ac_load_line_x10 = 8'h0a;
         4'h2:    o_ac_load_line_x10 = 8'h0f;
         4'h3:    o_ac_load_line_x10 = 8'h14;
         4'h4:    o_ac_load_line_x10 = 8'h19;
         4'h5:    o_ac_load_line_x10 = 8'h1e;
         4'h6:    o_ac_load_line_x10 = 8'h23;
         4'h7:    o_ac_load_line_x10 = 8'h28;
         4'h8:    o_ac_load_line_x10 = 8'h32;
         4'h9:    o_ac_load_line_x10 = 8'h3c;
         4'ha:    o_ac_load_line_x10 = 8'h46;
         4'hb:    o_ac_load_line_x10 = 8'h5a;
         4'hc:    o_ac_load_line_x10 = 8'h64;
         4'hd:    o_ac_load_line_x10 = 8'h78;
         4'he:    o_ac_load_line_x10 = 8'h82;
         default: o_ac_load_line_x10 = 8'h96;
      endcase
   end
endmodule // vocr_decode
`default_nettype wire

/* File: vocr_regs.sv */
// Offset trim and loop compensation register bank behind byte commands
// Function
// - With 5 mV steps the trim is signed at 0.5 mV per LSB, -64 to +63.5 mV.
// - With 10 mV steps the trim is signed at 1.0 mV per LSB, -128 to +127 mV.
// - The trim is one two's-complement field over bits 7 to 0.
// - Primary compensation holds gain in bits 7:4 and load line in bits 3:0.
// - Gain codes 0 to 11 decode to 0.3 through 7.0 in table order.
// - All sixteen load-line codes decode to 0.5 through 15.0 in table order.
// - A secondary compensation register at command AAh holds three fields.
// - Each register is written and read as a single byte.
// - Step select 01 or 10 means 5 mV steps, 00 or 11 means 10 mV steps.
// - Secondary fields sit at 7:6 integrator gain, 5:3 time, 2:0 ramp.
`timescale 1ns/10ps
`default_nettype none
`include "vocr_map.svh"
module vocr_regs (
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_nrst,
   input  wire vocr_pkg::vocr_req_s      i_req,
   input  wire vocr_pkg::vocr_nvm_s      i_nvm,
   input  wire logic [1:0]               i_vid_step_select,
   output logic                          o_ready,
   output logic                          o_ack,
   output logic      [7:0]               o_rdata,
   output logic                          o_rvalid,
   output vocr_pkg::vocr_nvm_s           o_regs,
   output vocr_pkg::vocr_tenth_mv_t      o_offset_tenth_mv,
   output logic                          o_step_5mv,
   output logic      [6:0]               o_ac_path_gain_x10,
   output logic      [7:0]               o_ac_load_line_x10,
   output logic                          o_gain_reserved,
   output logic      [1:0]               o_int_gain,
   output logic      [2:0]               o_int_time,
   output logic      [2:0]               o_ramp_amp
);
   logic                  rst_meta_q;
   logic                  rst_sync_q;
   logic                  rst_n;
   vocr_pkg::vocr_state_e state_q;
   logic [2:0]            load_cnt_q;
   logic [7:0]            trim_q;
   logic [7:0]            comp1_q;
   logic [7:0]            comp2_q;
   logic                  hit;
   logic signed [8:0]     trim_x1;
   logic signed [8:0]     trim_x2;

   // Reset release through two stages
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Load sequencer; the NVM image is sampled by the clock, never by reset
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= vocr_pkg::VOCR_ST_RESET;
         load_cnt_q <= 3'h0;
      end else begin
         case (state_q)
            vocr_pkg::VOCR_ST_RESET: begin
               state_q    <= vocr_pkg::VOCR_ST_LOAD;
               load_cnt_q <= 3'h0;
            end
            vocr_pkg::VOCR_ST_LOAD: begin
               load_cnt_q <= load_cnt_q + 3'h1;
               if (load_cnt_q == `VOCR_NVM_LOAD_CYCLES - 3'h1) begin
                  state_q <= vocr_pkg::VOCR_ST_READY;
               end
            end
            vocr_pkg::VOCR_ST_READY: state_q <= vocr_pkg::VOCR_ST_READY;
            default:                 state_q <= vocr_pkg::VOCR_ST_RESET;
         endcase
      end
   end
   assign o_ready = (state_q == vocr_pkg::VOCR_ST_READY);

   assign hit = (i_req.cmd == `VOCR_OFS_OFFSET_TRIM) || (i_req.cmd == `VOCR_OFS_COMP_PRIMARY)
              || (i_req.cmd == `VOCR_OFS_COMP_SECOND);
   // Ack only mapped commands once loaded; earlier access is refused
   assign o_ack = o_ready && hit && (i_req.wr || i_req.rd);

   // Register storage: NVM image during load, byte writes afterwards
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         trim_q  <= `VOCR_RST_BYTE;
         comp1_q <= `VOCR_RST_BYTE;
         comp2_q <= `VOCR_RST_BYTE;
      end else if (state_q == vocr_pkg::VOCR_ST_LOAD) begin
         trim_q  <= i_nvm.offset_trim;
         comp1_q <= i_nvm.comp_primary;
         comp2_q <= i_nvm.comp_second;
      end else if (o_ready && i_req.wr) begin
         // Reserved gain codes are stored as written; host must avoid them
         case (i_req.cmd)
            `VOCR_OFS_OFFSET_TRIM:  trim_q  <= i_req.wdata;
            `VOCR_OFS_COMP_PRIMARY: comp1_q <= i_req.wdata;
            `VOCR_OFS_COMP_SECOND:  comp2_q <= i_req.wdata;
            default:                trim_q  <= trim_q;
         endcase
      end
   end

   // Read data registered one cycle after the request
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata  <= `VOCR_RST_BYTE;
         o_rvalid <= 1'b0;
      end else begin
         // Unmapped reads clear the data byte but raise no valid
         o_rvalid <= o_ready && i_req.rd && hit;
         if (o_ready && i_req.rd) begin
            case (i_req.cmd)
               `VOCR_OFS_OFFSET_TRIM:  o_rdata <= trim_q;
               `VOCR_OFS_COMP_PRIMARY: o_rdata <= comp1_q;
               `VOCR_OFS_COMP_SECOND:  o_rdata <= comp2_q;
               default:                o_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Live settings follow the stored bytes with no restart
   assign o_regs.offset_trim  = trim_q;
   assign o_regs.comp_primary = comp1_q;
   assign o_regs.comp_second  = comp2_q;
   assign o_int_gain = comp2_q[`VOCR_IGAIN_MSB:`VOCR_IGAIN_LSB];
   assign o_int_time = comp2_q[`VOCR_ITIME_MSB:`VOCR_ITIME_LSB];
   assign o_ramp_amp = comp2_q[`VOCR_RAMP_MSB:`VOCR_RAMP_LSB];

   // Offset scaling; 5 mV step doubles nothing, 10 mV step doubles the tenths
   assign o_step_5mv = (i_vid_step_select == 2'b01) || (i_vid_step_select == 2'b10);
   assign trim_x1 = {trim_q[7], trim_q};
   assign trim_x2 = {trim_q, 1'b0};
   // 0.5 mV = 5 tenths, 1.0 mV = 10 tenths per LSB
   assign o_offset_tenth_mv = o_step_5mv
      ? 12'(signed'(trim_x1) * 12'sd5)
      : 12'(signed'(trim_x2) * 12'sd5);

   vocr_decode u_decode (
      .i_comp_primary     (comp1_q),
      .o_ac_path_gain_x10      (o_ac_path_gain_x10),
      .o_ac_load_line_x10 (o_ac_load_line_x10),
      .o_gain_reserved    (o_gain_reserved)
   );

   // Nothing is acknowledged or answered before the image is in place
   a_no_early_ack: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      !o_ready |-> !o_ack) else $error("ack before load");
   a_no_early_read: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (!o_ready && i_req.rd) |=> !o_rvalid) else $error("read answered before load");
   a_early_write_lost: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (state_q == vocr_pkg::VOCR_ST_LOAD && i_req.wr) |=> (o_regs == $past(i_nvm)))
      else $error("write landed during load");

   // Load length and the image that it leaves behind
   a_load_image: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (state_q == vocr_pkg::VOCR_ST_LOAD) |=> (trim_q == $past(i_nvm.offset_trim)))
      else $error("trim not loaded from nvm");
   a_load_count: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (state_q == vocr_pkg::VOCR_ST_LOAD) |-> (load_cnt_q < `VOCR_NVM_LOAD_CYCLES)) else $error("load overrun");
   a_ready_bound: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (state_q == vocr_pkg::VOCR_ST_RESET) |-> ##[1:5] o_ready) else $error("load too slow");
   a_ready_holds: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      o_ready |=> o_ready) else $error("ready dropped");

   // Byte writes land on the next edge and steer the live outputs at once
   a_write_trim: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_ready && i_req.wr && i_req.cmd == `VOCR_OFS_OFFSET_TRIM) |=> (o_regs.offset_trim == $past(i_req.wdata)))
      else $error("trim write lost");
   a_write_comp1: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_ready && i_req.wr && i_req.cmd == `VOCR_OFS_COMP_PRIMARY) |=> (comp1_q == $past(i_req.wdata)))
      else $error("primary write lost");
   a_write_comp2: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_ready && i_req.wr && i_req.cmd == `VOCR_OFS_COMP_SECOND) |=> (comp2_q == $past(i_req.wdata)))
      else $error("secondary write lost");
   a_unmapped_quiet: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_ready && !hit) |=> (o_regs == $past(o_regs) && !o_rvalid))
      else $error("unmapped command acted");

   // Read answers carry the stored byte; a same-cycle write shows next time
   a_read_back: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_ready && i_req.rd && !i_req.wr && i_req.cmd == `VOCR_OFS_COMP_PRIMARY) |=> (o_rvalid && o_rdata == comp1_q))
      else $error("readback mismatch");
   a_read_trim: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_ready && i_req.rd && i_req.cmd == `VOCR_OFS_OFFSET_TRIM) |=> (o_rvalid && o_rdata == $past(trim_q)))
      else $error("trim readback mismatch");
   a_read_old_byte: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_ready && i_req.rd && i_req.wr && i_req.cmd == `VOCR_OFS_COMP_SECOND) |=> (o_rdata == $past(comp2_q)))
      else $error("read with write not old byte");
   a_rdata_holds: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      !(o_ready && i_req.rd) |=> $stable(o_rdata)) else $error("read data moved");

   // Scaling and field splits of the live bytes
   a_step_scale: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (!o_step_5mv && trim_q == 8'h80) |-> (o_offset_tenth_mv == -12'sd1280)) else $error("10mV scale");
   a_half_scale: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_step_5mv && trim_q == 8'h7f) |-> (o_offset_tenth_mv == 12'sd635)) else $error("5mV scale");
   a_trim_sign: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (o_offset_tenth_mv[11] == trim_q[7])) else $error("offset sign lost");
   a_step_select: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (i_vid_step_select == 2'b00 || i_vid_step_select == 2'b11) |-> !o_step_5mv)
      else $error("step select decode");
   a_fields_sec: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      ({o_int_gain, o_int_time, o_ramp_amp} == comp2_q)) else $error("secondary split");
   a_gain_table: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (comp1_q[7:4] == 4'hb) |-> (o_ac_path_gain_x10 == 7'h46 && !o_gain_reserved)) else $error("gain decode");
   a_ll_table: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (comp1_q[3:0] == 4'hf) |-> (o_ac_load_line_x10 == 8'h96)) else $error("load line decode");
endmodule // vocr_regs
`default_nettype wire

/* File: vocr_host_model.sv */
// Host model issuing single-byte register commands
`timescale 1ns/10ps
`default_nettype none
module vocr_host_model (
   input  wire logic              i_clk_sys,
   input  wire logic              i_ack,
   output var vocr_pkg::vocr_req_s o_req
);
   // Idle bus at time zero
   initial o_req = '{1'b0, 1'b0, 8'h00, 8'h00};
   // One whole byte per request; callers never write reserved gain codes
   task automatic xfer(input logic wr, input logic rd, input logic [7:0] cmd,
                       input logic [7:0] wd, output logic ack);
      @(negedge i_clk_sys);
      o_req = '{wr, rd, cmd, wd};
      @(posedge i_clk_sys);
      ack = i_ack;
      @(negedge i_clk_sys);
      // Released lines show the inverse, so a stale byte never looks valid
      o_req = '{1'b0, 1'b0, ~cmd, ~wd};
   endtask
endmodule // vocr_host_model
`default_nettype wire

/* File: vocr_regs_tb.sv */
// Self-checking bench for the offset and compensation register bank
`timescale 1ns/10ps
`default_nettype none
module vocr_regs_tb;
   logic                     i_clk_sys, i_nrst, ready, ack, rvalid, s5, rsv;
   logic [1:0]               step, ig;
   logic [2:0]               it, ra;
   logic [6:0]               gx;
   logic [7:0]               rdata, llx, v, shadow [3];
   logic [31:0]              rnd;
   vocr_pkg::vocr_req_s      req;
   vocr_pkg::vocr_nvm_s      nvm, regs;
   vocr_pkg::vocr_tenth_mv_t ofs, e;
   logic [7:0]               exp_q [$];
   int                       failures, compares;
   localparam logic [7:0] GX [16] = '{8'h03, 8'h05, 8'h0a, 8'h0f, 8'h14, 8'h19, 8'h1e, 8'h23,
                                      8'h28, 8'h32, 8'h3c, 8'h46, 8'h03, 8'h03, 8'h03, 8'h03};
   localparam logic [7:0] LX [16] = '{8'h05, 8'h0a, 8'h0f, 8'h14, 8'h19, 8'h1e, 8'h23, 8'h28,
                                      8'h32, 8'h3c, 8'h46, 8'h5a, 8'h64, 8'h78, 8'h82, 8'h96};
   vocr_regs i_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(req), .i_nvm(nvm),
      .i_vid_step_select(step), .o_ready(ready), .o_ack(ack), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_regs(regs), .o_offset_tenth_mv(ofs), .o_step_5mv(s5), .o_ac_path_gain_x10(gx),
      .o_ac_load_line_x10(llx), .o_gain_reserved(rsv), .o_int_gain(ig), .o_int_time(it),
      .o_ramp_amp(ra));
   vocr_host_model i_host (.i_clk_sys(i_clk_sys), .i_ack(ack), .o_req(req));
   // 20 MHz clock
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Read expectation is noted before the request, from the old shadow byte
   task automatic acc(input logic wr, input logic rd, input logic [7:0] cmd, input logic [7:0] wd,
                      input logic hit);
      logic a;
      if (rd && hit) exp_q.push_back(shadow[cmd - 8'ha8]);
      i_host.xfer(wr, rd, cmd, wd, a);
      chk(a, hit);
      if (wr && hit) shadow[cmd - 8'ha8] = wd;
   endtask
   // Reset with a fresh image; a request during the load is refused
   task automatic do_reset();
      nvm = rnd[23:0];
      rnd = lfsr(rnd);
      i_nrst = 1'b0;
      repeat (8) @(negedge i_clk_sys);
      i_nrst = 1'b1;
      // Lands inside the load window, so it must be refused and never answered
      repeat (2) @(negedge i_clk_sys);
      acc(1'b1, 1'b1, 8'ha8, 8'h55, 1'b0);
      for (int n = 0; n < 20 && ready !== 1'b1; n++) @(negedge i_clk_sys);
      {shadow[0], shadow[1], shadow[2]} = nvm;
      chk(ready, 1'b1);
      chk(regs, nvm);
      // Gain decode follows the image, reserved codes included, and reads back unchanged
      chk(rsv, nvm.comp_primary[7:4] >= 4'hc);
      chk(gx, GX[nvm.comp_primary[7:4]]);
      acc(1'b0, 1'b1, 8'ha9, 8'h00, 1'b1);
      $display("test reset done");
   endtask
   // Read answers are matched in order; a stray answer is a mismatch
   always @(negedge i_clk_sys) if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(24'h1, 24'h0);
      else chk(rdata, exp_q.pop_front());
   end
   initial begin
      i_nrst = 1'b0;
      step = 2'b00;
      nvm = '0;
      rnd = 32'h933fed36;
      failures = 0;
      compares = 0;
      do_reset();
      // Every load-line code and every legal gain code; the host keeps off reserved gains
      for (int c = 0; c < 16; c++) begin
         v = {(c < 12) ? c[3:0] : c[3:0] - 4'h8, 4'hf - c[3:0]};
         acc(1'b1, 1'b0, 8'ha9, v, 1'b1);
         chk(gx, GX[v[7:4]]);
         chk(llx, LX[v[3:0]]);
         chk(rsv, 1'b0);
         acc(1'b0, 1'b1, 8'ha9, 8'h00, 1'b1);
      end
      $display("test compensation codes done");
      // Offset at its low end under step 00 and high end under step 01, all step codes in turn, plus secondary fields
      for (int k = 0; k < 12; k++) begin
         v = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : rnd[7:0];
         step = k[1:0];
         acc(1'b1, 1'b0, 8'ha8, v, 1'b1);
         e = {{4{v[7]}}, v};
         e = 12'(e * ((step == 2'b01 || step == 2'b10) ? 5 : 10));
         chk(ofs, e);
         chk(s5, step == 2'b01 || step == 2'b10);
         acc(1'b1, 1'b0, 8'haa, rnd[15:8], 1'b1);
         chk({ig, it, ra}, rnd[15:8]);
         acc(1'b0, 1'b1, 8'ha8, 8'h00, 1'b1);
         rnd = lfsr(rnd);
      end
      $display("test offset and secondary done");
      // Unmapped commands change nothing; write with read returns the old byte
      acc(1'b1, 1'b0, 8'ha7, 8'h3c, 1'b0);
      acc(1'b0, 1'b1, 8'hab, 8'h00, 1'b0);
      chk(regs, {shadow[0], shadow[1], shadow[2]});
      acc(1'b1, 1'b1, 8'haa, rnd[7:0], 1'b1);
      $display("test refusals done");
      // Second reset mid-run reloads every register
      do_reset();
      for (int i = 0; i < 3; i++) acc(1'b0, 1'b1, 8'ha8 + i[7:0], 8'h00, 1'b1);
      repeat (3) @(negedge i_clk_sys);
      chk(24'(exp_q.size()), 24'h0);
      $display("test second reset done");
      complete_run();
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      failures++;
      complete_run();
   end
endmodule // vocr_regs_tb
`default_nettype wire
